// ===== hdl/dcff_consts.vh
`ifndef DCFF_CONSTS_VH
`define DCFF_CONSTS_VH
`define DCFF_DW          36
`define DCFF_AW          6
`define DCFF_CW          7
`define DCFF_DEPTH       7'h40
`define DCFF_OFW         6
`define DCFF_ZERO_PTR    6'h00
`define DCFF_ZERO_CNT    7'h00
`define DCFF_ONE_CNT     7'h01
`define DCFF_ZERO_DATA   36'h000000000
`define DCFF_FT_LAT      2'h2
`define DCFF_OFS_HI      11
`define DCFF_OFS_LO      6
`define DCFF_SER_W       12
`endif

// ===== hdl/dcff_skid.v
`timescale 1ns/1ps
`default_nettype none
`include "dcff_consts.vh"
// Two-entry buffer between the memory read side and the output register.
module dcff_skid (
	input  wire                 clk_i,
	input  wire                 rst_n_i,
	input  wire                 clr_i,
	input  wire                 in_valid_i,
	output wire                 in_ready_o,
	input  wire [`DCFF_DW-1:0]  in_data_i,
	output wire                 out_valid_o,
	input  wire                 out_ready_i,
	output wire [`DCFF_DW-1:0]  out_data_o
);
	reg [`DCFF_DW-1:0] slot [0:1];
	reg                wp;
	reg                rp;
	reg [1:0]          cnt;

	assign in_ready_o  = (cnt != 2'h2);
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o  = slot[rp];

	// Both sides may move in one cycle; the count tracks the difference.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else if (clr_i) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (in_valid_i && in_ready_o) begin
				wp <= ~wp;
			end
			if (out_valid_o && out_ready_i) begin
				rp <= ~rp;
			end
			cnt <= cnt + {1'b0, in_valid_i && in_ready_o} - {1'b0, out_valid_o && out_ready_i};
		end
	end

	// Storage holds no control meaning, so it needs no reset.
	always @(posedge clk_i) begin
		if (in_valid_i && in_ready_o) begin
			slot[wp] <= in_data_i;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/dcff_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dcff_consts.vh"
// Overview of operation
// - Full reset zeroes both pointers and the output register.
// - Full reset latches mode, port timing, default offsets, programming method, flag timing.
// - Asynchronous flag timing: almost flags fall on one clock, rise on the other.
// - Synchronous flag timing: almost-empty on read edges, almost-full on write edges.
// - Flag timing select sampled at full reset, low asynchronous, high synchronous.
// - Mark sampled on read clock records current read location as replay point.
// - Replay strobe low returns read pointer to recorded replay point.
// - Idle device reports power-down; any active reset, write, read or serial enable, mark or replay strobe leaves it.
// - Outputs driven under output enable and a read-clock-registered chip select.
// - During either reset only the output enable controls the outputs.
// - Read port timing select latched at full reset; strobe reading needs standard mode.
// - Write port timing select latched at full reset.
// - Empty flag in standard mode, output-ready in fall-through, one per half.
// - Full flag in standard mode, input-ready in fall-through mode.
// - Flag selects plus offset access choose one of eight defaults and method.
// - Mode pin picks mode at full reset, then serves as serial offset input.
// - Offset access redirects enabled reads, and enabled writes in the parallel method only, to the offset registers.
// - Almost-empty low when count below empty offset, else high.
// - Almost-full high when free space exceeds full offset, else low.
// - Clocked read with enable reads a word, or offsets when offset access active.
// - Write and read data are 36 bits wide.
// - Fall-through: first word appears after three read clock transitions unrequested.
// - Parallel offset load by write with access; serial load by serial enable.
// - Replay without mark goes to zero, flags follow the restored count, write side untouched.
module dcff_top (
	input  wire                 clk_i,
	input  wire                 rst_n_i,
	input  wire                 full_reset_n_i,
	input  wire                 pointer_only_reset_n_i,
	input  wire                 wr_clk_i,
	input  wire                 wr_en_n_i,
	input  wire [`DCFF_DW-1:0]  write_data_i,
	input  wire                 rd_clk_i,
	input  wire                 rd_en_n_i,
	input  wire                 ser_clk_i,
	input  wire                 serial_load_enable_n_i,
	input  wire                 mode_or_serial_pin_i,
	input  wire                 offset_access_n_i,
	input  wire                 flag_default_select_0_i,
	input  wire                 flag_default_select_1_i,
	input  wire                 almost_flag_timing_select_i,
	input  wire                 read_port_timing_select_i,
	input  wire                 write_port_timing_select_i,
	input  wire                 mark_i,
	input  wire                 replay_strobe_n_i,
	input  wire                 output_enable_n_i,
	input  wire                 read_chip_select_n_i,
	output reg  [`DCFF_DW-1:0]  read_data_o,
	output reg                  read_data_oe_n_o,
	output reg  [1:0]           empty_flag_n_o,
	output reg  [1:0]           full_flag_n_o,
	output reg  [1:0]           almost_empty_flag_n_o,
	output reg  [1:0]           almost_full_flag_n_o,
	output reg                  power_down_o,
	output reg                  fall_through_mode_o,
	output reg                  read_port_clocked_o,
	output reg                  write_port_clocked_o
);
	localparam ST_RUN   = 2'b01;
	localparam ST_RESET = 2'b10;

	// Default offset table, index {offset access, select 1, select 0}.
	function [`DCFF_OFW-1:0] dcff_default_ofs;
		input [2:0] sel;
		begin
			dcff_default_ofs = {3'h0, sel} + 6'h01;
		end
	endfunction

	// Three-stage sampler for inputs that live outside clk_i; a change counts once stages two and three agree.
	wire [12:0] raw = {full_reset_n_i, pointer_only_reset_n_i, wr_clk_i, wr_en_n_i, rd_clk_i, rd_en_n_i,
		ser_clk_i, serial_load_enable_n_i, mode_or_serial_pin_i, offset_access_n_i, mark_i,
		replay_strobe_n_i, read_chip_select_n_i};
	reg  [12:0] s1;
	reg  [12:0] s2;
	reg  [12:0] s3;
	reg  [12:0] q;
	genvar gi;
	generate
		for (gi = 0; gi < 13; gi = gi + 1) begin : g_sync
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1[gi] <= 1'b1;
					s2[gi] <= 1'b1;
					s3[gi] <= 1'b1;
					q[gi]  <= 1'b1;
				end else begin
					s1[gi] <= raw[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi]) begin
						q[gi] <= s3[gi];
					end
				end
			end
		end
	endgenerate
	wire mrs_n = q[12];
	wire prs_n = q[11];
	wire wclk  = q[10];
	wire wen_n = q[9];
	wire rclk  = q[8];
	wire ren_n = q[7];
	wire sclk  = q[6];
	wire sen_n = q[5];
	wire si    = q[4];
	wire ld_n  = q[3];
	wire mark  = q[2];
	wire rt_n  = q[1];
	wire rcs_n = q[0];

	// Edge detection on the settled copies of the link clocks and the replay strobe.
	reg wclk_d;
	reg rclk_d;
	reg sclk_d;
	reg rt_d;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Match the settled copies' reset level, so no false rising edge follows reset.
			wclk_d <= 1'b1;
			rclk_d <= 1'b1;
			sclk_d <= 1'b1;
			rt_d   <= 1'b1;
		end else begin
			wclk_d <= wclk;
			rclk_d <= rclk;
			sclk_d <= sclk;
			rt_d   <= rt_n;
		end
	end
	wire in_reset = !mrs_n || !prs_n;
	wire w_edge   = wclk && !wclk_d && !in_reset;
	wire r_edge   = rclk && !rclk_d && !in_reset;
	wire r_any    = (rclk != rclk_d) && !in_reset;
	wire s_edge   = sclk && !sclk_d && !in_reset;
	wire rt_fall  = !rt_n && rt_d && !in_reset;

	// Configuration and offsets.
	reg                 cfg_pfm_sync;
	reg                 cfg_serial;
	reg [`DCFF_OFW-1:0] ofs_empty;
	reg [`DCFF_OFW-1:0] ofs_full;
	reg [`DCFF_SER_W-1:0] ser_sh;
	reg [3:0]           ser_cnt;
	reg [1:0]           state;

	reg [`DCFF_DW-1:0]  mem [0:`DCFF_DEPTH-1];
	reg [`DCFF_AW:0]    wptr;
	reg [`DCFF_AW:0]    rptr;
	reg [`DCFF_AW:0]    mark_ptr;
	reg                 mark_set;
	reg [1:0]           ft_cnt;
	reg                 bf_pend;
	reg                 out_valid;
	reg [1:0]           bf_occ;
	// Words parked in the buffer are still stored; leaving them out would let the flags run ahead.
	wire [`DCFF_CW-1:0] ptr_diff = wptr - rptr;
	wire [`DCFF_CW-1:0] count  = ptr_diff + {5'h0, bf_occ};
	wire [`DCFF_CW-1:0] free_c = `DCFF_DEPTH - count;
	wire                mem_empty = (count == `DCFF_ZERO_CNT);
	wire                mem_full  = (count == `DCFF_DEPTH);

	// Buffer between memory and the output register.
	wire                 bf_in_ready;
	wire                 bf_out_valid;
	wire [`DCFF_DW-1:0]  bf_out_data;
	wire                 data_rd  = r_edge && !ren_n && ld_n;
	wire                 ft_take  = fall_through_mode_o && !out_valid && bf_out_valid && (ft_cnt == `DCFF_FT_LAT) && r_any;
	wire                 bf_take  = bf_out_valid && ((data_rd && (!fall_through_mode_o || out_valid)) || ft_take);
	wire                 bf_push  = (ptr_diff != `DCFF_ZERO_CNT) && bf_in_ready && !bf_pend;
	dcff_skid u_skid (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.clr_i       (in_reset || rt_fall),
		.in_valid_i  (bf_push),
		.in_ready_o  (bf_in_ready),
		.in_data_i   (mem[rptr[`DCFF_AW-1:0]]),
		.out_valid_o (bf_out_valid),
		.out_ready_i (bf_take),
		.out_data_o  (bf_out_data)
	);

	// Full reset latches configuration; pointer-only reset leaves it alone.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_RESET;
			fall_through_mode_o  <= 1'b0;
			read_port_clocked_o  <= 1'b1;
			write_port_clocked_o <= 1'b1;
			cfg_pfm_sync <= 1'b0;
			cfg_serial   <= 1'b0;
			ofs_empty    <= dcff_default_ofs(3'h0);
			ofs_full     <= dcff_default_ofs(3'h0);
			ser_sh  <= {`DCFF_SER_W{1'b0}};
			ser_cnt <= 4'h0;
		end else begin
			case (state)
				ST_RESET: begin
					if (!mrs_n) begin
						fall_through_mode_o  <= si && read_port_timing_select_i;
						read_port_clocked_o  <= read_port_timing_select_i;
						write_port_clocked_o <= write_port_timing_select_i;
						cfg_pfm_sync <= almost_flag_timing_select_i;
						cfg_serial   <= !ld_n;
						ofs_empty <= dcff_default_ofs({ld_n, flag_default_select_1_i, flag_default_select_0_i});
						ofs_full  <= dcff_default_ofs({ld_n, flag_default_select_1_i, flag_default_select_0_i});
						ser_cnt   <= 4'h0;
					end else begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!mrs_n) begin
						state <= ST_RESET;
					end else if (w_edge && !wen_n && !ld_n && !cfg_serial) begin
						ofs_empty <= write_data_i[`DCFF_OFW-1:0];
						ofs_full  <= write_data_i[`DCFF_OFS_HI:`DCFF_OFS_LO];
					end else if (s_edge && !sen_n && !ld_n && cfg_serial) begin
						ser_sh  <= {si, ser_sh[`DCFF_SER_W-1:1]};
						ser_cnt <= (ser_cnt == 4'hb) ? 4'h0 : ser_cnt + 4'h1;
						if (ser_cnt == 4'hb) begin
							ofs_empty <= ser_sh[`DCFF_SER_W-1:`DCFF_OFS_LO];
							ofs_full  <= {si, ser_sh[`DCFF_SER_W-1:`DCFF_OFS_LO+1]};
						end
					end
				end
				default: state <= ST_RESET;
			endcase
		end
	end

	// Write side, pointers, mark and replay.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr <= `DCFF_ZERO_CNT;
			rptr <= `DCFF_ZERO_CNT;
			mark_ptr <= `DCFF_ZERO_CNT;
			mark_set <= 1'b0;
			bf_pend  <= 1'b0;
			bf_occ   <= 2'h0;
		end else if (in_reset) begin
			wptr <= `DCFF_ZERO_CNT;
			rptr <= `DCFF_ZERO_CNT;
			mark_ptr <= `DCFF_ZERO_CNT;
			mark_set <= 1'b0;
			bf_pend  <= 1'b0;
			bf_occ   <= 2'h0;
		end else begin
			bf_pend <= 1'b0;
			if (w_edge && !wen_n && ld_n && !mem_full) begin
				mem[wptr[`DCFF_AW-1:0]] <= write_data_i;
				wptr <= wptr + `DCFF_ONE_CNT;
			end
			if (r_edge && mark) begin
				mark_ptr <= rptr - {5'h0, bf_out_valid} - {6'h0, out_valid};
				mark_set <= 1'b1;
			end
			if (rt_fall) begin
				rptr <= mark_set ? mark_ptr : `DCFF_ZERO_CNT;
				bf_occ <= 2'h0;
			end else begin
				if (bf_push) begin
					rptr <= rptr + `DCFF_ONE_CNT;
				end
				bf_occ <= bf_occ + {1'b0, bf_push} - {1'b0, bf_take};
			end
		end
	end

	// Read side output register, latency counter and output drive.
	reg rcs_q;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			read_data_o <= `DCFF_ZERO_DATA;
			out_valid   <= 1'b0;
			ft_cnt      <= 2'h0;
			rcs_q       <= 1'b1;
			read_data_oe_n_o <= 1'b1;
			power_down_o     <= 1'b0;
		end else begin
			if (r_edge) begin
				rcs_q <= rcs_n;
			end
			// Output enable is taken directly; only one flop of delay.
			read_data_oe_n_o <= in_reset ? output_enable_n_i : (output_enable_n_i || rcs_q);
			power_down_o <= mrs_n && prs_n && wen_n && ren_n && sen_n && !mark && rt_n;
			if (in_reset || rt_fall) begin
				read_data_o <= in_reset ? `DCFF_ZERO_DATA : read_data_o;
				out_valid   <= 1'b0;
				ft_cnt      <= 2'h0;
			end else begin
				if (fall_through_mode_o && bf_out_valid && !out_valid && r_any && ft_cnt != `DCFF_FT_LAT) begin
					ft_cnt <= ft_cnt + 2'h1;
				end
				if (r_edge && !ren_n && !ld_n) begin
					read_data_o <= {{(`DCFF_DW-12){1'b0}}, ofs_full, ofs_empty};
				end else if (bf_take) begin
					read_data_o <= bf_out_data;
					out_valid   <= 1'b1;
					ft_cnt      <= 2'h0;
				end else if (data_rd && fall_through_mode_o) begin
					out_valid <= 1'b0;
				end
			end
		end
	end

	// Flags: empty/ready and full/ready, doubled for the two halves.
	wire ef_n = fall_through_mode_o ? !out_valid : !mem_empty;
	wire ff_n = fall_through_mode_o ? mem_full : !mem_full;
	wire pae_now = (count >= {1'b0, ofs_empty});
	wire paf_now = (free_c > {1'b0, ofs_full});
	// Flags act one cycle after the link edge, once the pointer it moved has settled.
	reg w_ev;
	reg r_ev;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_ev <= 1'b0;
			r_ev <= 1'b0;
		end else begin
			w_ev <= w_edge;
			r_ev <= r_edge;
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			empty_flag_n_o <= 2'b00;
			full_flag_n_o  <= 2'b11;
			almost_empty_flag_n_o <= 2'b00;
			almost_full_flag_n_o  <= 2'b11;
		end else begin
			empty_flag_n_o <= {2{fall_through_mode_o ? !ef_n : ef_n}} ^ {2{fall_through_mode_o}};
			full_flag_n_o  <= {2{ff_n}};
			if (in_reset || !cfg_pfm_sync) begin
				// almost-empty low on read edges via count drop, high on write edges; almost-full the reverse.
				if ((r_ev && !pae_now) || (w_ev && pae_now) || in_reset) begin
					almost_empty_flag_n_o <= {2{pae_now}};
				end
				if ((w_ev && !paf_now) || (r_ev && paf_now) || in_reset) begin
					almost_full_flag_n_o <= {2{paf_now}};
				end
			end else begin
				if (r_ev) begin
					almost_empty_flag_n_o <= {2{pae_now}};
				end
				if (w_ev) begin
					almost_full_flag_n_o <= {2{paf_now}};
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/dcff_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcff_consts.vh"
// Watches reset, output-drive and flag relations at the top ports.
module dcff_props (
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	input wire logic               full_reset_n_i,
	input wire logic               wr_en_n_i,
	input wire logic               output_enable_n_i,
	input wire logic               read_chip_select_n_i,
	input wire logic [`DCFF_DW-1:0] read_data_o,
	input wire logic               read_data_oe_n_o,
	input wire logic [1:0]         empty_flag_n_o,
	input wire logic [1:0]         full_flag_n_o,
	input wire logic [1:0]         almost_empty_flag_n_o,
	input wire logic [1:0]         almost_full_flag_n_o,
	input wire logic               power_down_o,
	input wire logic               fall_through_mode_o,
	input wire logic               read_port_clocked_o,
	input wire logic               write_port_clocked_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Six cycles of slack cover the reset synchroniser.
	reset_zero_a: assert property (!full_reset_n_i [*6] |-> read_data_o == `DCFF_ZERO_DATA)
		else $error("output word not cleared in full reset");
	reset_drive_a: assert property ((!full_reset_n_i && !output_enable_n_i && read_chip_select_n_i) [*6]
		|-> !read_data_oe_n_o)
		else $error("chip select floated outputs during reset");
	oe_float_a: assert property (output_enable_n_i [*4] |-> read_data_oe_n_o)
		else $error("outputs driven with output enable off");
	config_hold_a: assert property (full_reset_n_i [*8] |-> $stable(fall_through_mode_o)
		&& $stable(read_port_clocked_o) && $stable(write_port_clocked_o))
		else $error("configuration moved outside full reset");
	flag_pair_a: assert property (!(^empty_flag_n_o) && !(^full_flag_n_o))
		else $error("flag halves disagree");
	empty_full_a: assert property (!fall_through_mode_o |-> empty_flag_n_o[0] || full_flag_n_o[0])
		else $error("empty and full together");
	empty_almost_a: assert property ((!fall_through_mode_o && !empty_flag_n_o[0]) [*4]
		|-> !almost_empty_flag_n_o[0])
		else $error("almost empty off while empty");
	full_almost_a: assert property ((!fall_through_mode_o && !full_flag_n_o[0]) [*4]
		|-> !almost_full_flag_n_o[0])
		else $error("almost full off while full");
	wake_a: assert property (!wr_en_n_i [*6] |-> !power_down_o)
		else $error("power down held with write enable active");
endmodule

bind dcff_top dcff_props u_dcff_props (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .full_reset_n_i(full_reset_n_i), .wr_en_n_i(wr_en_n_i),
	.output_enable_n_i(output_enable_n_i), .read_chip_select_n_i(read_chip_select_n_i),
	.read_data_o(read_data_o), .read_data_oe_n_o(read_data_oe_n_o), .empty_flag_n_o(empty_flag_n_o),
	.full_flag_n_o(full_flag_n_o), .almost_empty_flag_n_o(almost_empty_flag_n_o),
	.almost_full_flag_n_o(almost_full_flag_n_o), .power_down_o(power_down_o),
	.fall_through_mode_o(fall_through_mode_o), .read_port_clocked_o(read_port_clocked_o),
	.write_port_clocked_o(write_port_clocked_o)
);
`default_nettype wire

// ===== sim/dcff_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcff_consts.vh"
// Writer and reader logic; each link clock only runs during its own transfer.
module dcff_link (
	input  wire logic               clk_i,
	output var  logic               wr_clk_o,
	output var  logic               rd_clk_o,
	output var  logic               wr_en_n_o,
	output var  logic               rd_en_n_o,
	output var  logic [`DCFF_DW-1:0] write_data_o
);
	initial begin
		wr_clk_o = 1'b0;
		rd_clk_o = 1'b0;
		wr_en_n_o = 1'b1;
		rd_en_n_o = 1'b1;
		write_data_o = `DCFF_ZERO_DATA;
	end

	// One 160 ns link period; enable and data lead the rising edge by two cycles.
	// Released data shows the inverse so a stale word never passes for a new one.
	task automatic op(input logic wr, input logic [`DCFF_DW-1:0] d);
		begin
			@(negedge clk_i);
			if (wr) begin
				wr_en_n_o = 1'b0;
				write_data_o = d;
			end else begin
				rd_en_n_o = 1'b0;
			end
			repeat (2) @(negedge clk_i);
			if (wr) wr_clk_o = 1'b1;
			else rd_clk_o = 1'b1;
			repeat (8) @(negedge clk_i);
			wr_clk_o = 1'b0;
			rd_clk_o = 1'b0;
			repeat (8) @(negedge clk_i);
			wr_en_n_o = 1'b1;
			rd_en_n_o = 1'b1;
			write_data_o = ~d;
		end
	endtask
endmodule
`default_nettype wire

// ===== sim/dcff_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcff_consts.vh"
module dcff_top_test;
	logic               clk_i = 1'b0;
	logic               rst_n_i, fr_n, pr_n, mode, almost_flag_timing_select, rpts, wpts, sel0, sel1, acc_n, oe_n, rcs_n, rt_n;
	logic               wclk, rclk, wen_n, ren_n, oe_n_o, pd, ft, rpc, wpc;
	logic [`DCFF_DW-1:0] wdata, rdata;
	logic [1:0]         ef, ff, ae, af;
	int                 err_total = 0;
	int                 compares = 0;
	int                 i;

	always #5 clk_i = ~clk_i;

	dcff_link u_dcff_link (.clk_i(clk_i), .wr_clk_o(wclk), .rd_clk_o(rclk), .wr_en_n_o(wen_n),
		.rd_en_n_o(ren_n), .write_data_o(wdata));

	// Serial loading and mark are left idle; offsets go in over the parallel path.
	dcff_top u_dcff_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .full_reset_n_i(fr_n), .pointer_only_reset_n_i(pr_n),
		.wr_clk_i(wclk), .wr_en_n_i(wen_n), .write_data_i(wdata), .rd_clk_i(rclk), .rd_en_n_i(ren_n),
		.ser_clk_i(1'b0), .serial_load_enable_n_i(1'b1), .mode_or_serial_pin_i(mode),
		.offset_access_n_i(acc_n), .flag_default_select_0_i(sel0), .flag_default_select_1_i(sel1),
		.almost_flag_timing_select_i(almost_flag_timing_select), .read_port_timing_select_i(rpts),
		.write_port_timing_select_i(wpts), .mark_i(1'b0), .replay_strobe_n_i(rt_n),
		.output_enable_n_i(oe_n), .read_chip_select_n_i(rcs_n), .read_data_o(rdata),
		.read_data_oe_n_o(oe_n_o), .empty_flag_n_o(ef), .full_flag_n_o(ff), .almost_empty_flag_n_o(ae),
		.almost_full_flag_n_o(af), .power_down_o(pd), .fall_through_mode_o(ft),
		.read_port_clocked_o(rpc), .write_port_clocked_o(wpc));

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic tally_and_finish;
		begin
			$display("checks %0d, mismatches %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	// Reads the offset pair back over the data outputs.
	task automatic offsets(input logic [11:0] exp);
		begin
			acc_n = 1'b0;
			u_dcff_link.op(1'b0, `DCFF_ZERO_DATA);
			acc_n = 1'b1;
			chk(rdata[11:0], exp);
		end
	endtask

	// A hang costs one mismatch and still ends in the report.
	initial begin
		#300000;
		err_total = err_total + 1;
		tally_and_finish;
	end

	initial begin
		rst_n_i = 0; fr_n = 0; pr_n = 1; mode = 0; almost_flag_timing_select = 0; rpts = 1; wpts = 1; sel0 = 0; sel1 = 0;
		acc_n = 1; oe_n = 0; rcs_n = 1; rt_n = 1;
		idle(12);
		rst_n_i = 1;
		idle(8);
		chk(oe_n_o, 1'b0);
		fr_n = 1;
		rcs_n = 0;
		idle(10);
		chk({ft, rpc, wpc}, 3'b011);
		chk(rdata, `DCFF_ZERO_DATA);
		chk({ef, ff}, 4'b0011);
		acc_n = 0;
		u_dcff_link.op(1'b1, 36'h0000000c2);
		acc_n = 1;
		offsets(12'h0c2);
		chk(oe_n_o, 1'b0);
		for (i = 1; i <= 3; i++) begin
			u_dcff_link.op(1'b1, 36'h000000a00 + i);
			if (i == 1) chk({ef, ae}, 4'b1100);
			if (i == 2) chk(ae, 2'b11);
		end
		u_dcff_link.op(1'b0, `DCFF_ZERO_DATA);
		chk(rdata, 36'h000000a01);
		u_dcff_link.op(1'b0, `DCFF_ZERO_DATA);
		chk({rdata, ae}, {36'h000000a02, 2'b00});
		rt_n = 0;
		idle(6);
		rt_n = 1;
		idle(10);
		u_dcff_link.op(1'b0, `DCFF_ZERO_DATA);
		chk(rdata, 36'h000000a01);
		pr_n = 0;
		idle(8);
		pr_n = 1;
		idle(10);
		chk({rdata, ef, ft}, {`DCFF_ZERO_DATA, 3'b000});
		offsets(12'h0c2);
		for (i = 0; i < 64; i++) begin
			u_dcff_link.op(1'b1, 36'h000000100 + i);
			if (i == 59) chk(af, 2'b11);
		end
		chk({af, ff}, 4'b0000);
		chk(ff[0] | ff[1], 1'b0);
		u_dcff_link.op(1'b1, 36'h000000fff);
		for (i = 0; i < 64; i++) begin
			u_dcff_link.op(1'b0, `DCFF_ZERO_DATA);
			if (i == 0) chk({rdata, ff}, {36'h000000100, 2'b11});
		end
		chk({rdata, ef}, {36'h00000013f, 2'b00});
		oe_n = 1;
		idle(4);
		chk(oe_n_o, 1'b1);
		oe_n = 0;
		rcs_n = 1;
		u_dcff_link.op(1'b0, `DCFF_ZERO_DATA);
		chk(oe_n_o, 1'b1);
		idle(30);
		chk(pd, 1'b1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
